// File: hcmc_pkg.sv
// Shared constants and types for the high-speed conditioner mode control.
// Assumes a single 100 MHz clock domain and inputs synchronous to it.
`default_nettype none
package hcmc_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int WAKE_SAMPLE_NS  = 1000; // Delay after shutdown release before sampling
  localparam int WAKE_SAMPLE_CYC = (WAKE_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W      = 8;

  // Serial target address (7 bit)
  localparam logic [6:0] TGT_ADDR = 7'h2C;

  // Register offsets
  localparam logic [7:0] OFS_EDGE   = 8'h01;
  localparam logic [7:0] OFS_CONFIG = 8'h03;
  localparam logic [7:0] OFS_STATIC = 8'h0E;
  localparam logic [7:0] OFS_RXGAIN = 8'h25;

  // Field positions
  localparam int EDGE_LVL_LSB   = 4;
  localparam int STATIC_LVL_LSB = 0;
  localparam int CFG_HOLD_BIT   = 0;

  // Reset values
  localparam logic [7:0] EDGE_RST       = 8'h00;
  localparam logic [3:0] EDGE_RSVD_RST  = 4'h0; // Hardware-set reserved nibble
  localparam logic [7:0] CONFIG_RST     = 8'h01;
  localparam logic [7:0] STATIC_RST     = 8'h00;
  localparam logic [3:0] STATIC_RSVD_RST = 4'h0;
  localparam logic [7:0] RXGAIN_RST     = 8'h00;
  localparam logic [7:0] UNMAPPED_RD    = 8'h00;

  // Strap decode tables
  localparam logic [3:0] EDGE_L0 = 4'h0;
  localparam logic [3:0] EDGE_L1 = 4'h3;
  localparam logic [3:0] EDGE_L2 = 4'h6;
  localparam logic [3:0] EDGE_L3 = 4'hA;
  localparam logic [3:0] STAT_L0 = 4'h0;
  localparam logic [3:0] STAT_L12 = 4'h2;
  localparam logic [3:0] STAT_L3 = 4'h6;
  localparam logic [7:0] RX_LOW  = 8'h00;
  localparam logic [7:0] RX_MID  = 8'h33;
  localparam logic [7:0] RX_HIGH = 8'h66;

  // Three-state receive gain strap code
  typedef enum logic [1:0] {
    RXS_LOW  = 2'h0,
    RXS_MID  = 2'h1,
    RXS_HIGH = 2'h2,
    RXS_RSVD = 2'h3
  } hcmc_rxs_t;

  // Line speed reported by the analog detector
  typedef enum logic [1:0] {
    SPD_NONE = 2'h0,
    SPD_LS   = 2'h1,
    SPD_FS   = 2'h2,
    SPD_HS   = 2'h3
  } hcmc_speed_t;

  // Compensation settings
  typedef struct packed {
    logic [3:0] edge_lvl;
    logic [3:0] static_lvl;
    logic [7:0] rx_gain;
  } hcmc_comp_t;

  // Register write request from the serial target
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } hcmc_wreq_t;
endpackage : hcmc_pkg
`default_nettype wire

// File: hcmc_strap_decode.sv
// Strap level decoder: boost level and receive gain straps to field values.
// Assumes the analog front end has already resolved pin resistance to codes.
`default_nettype none
module hcmc_strap_decode (
  input  wire logic [1:0]          i_boost_level, // Boost strap level 0..3
  input  wire logic [1:0]          i_rx_strap,    // Receive gain strap code
  output hcmc_pkg::hcmc_comp_t     o_comp        // Decoded settings
);
  // Edge level table
  function automatic logic [3:0] edge_of(input logic [1:0] lvl);
    case (lvl)
      2'd0:    edge_of = hcmc_pkg::EDGE_L0;
      2'd1:    edge_of = hcmc_pkg::EDGE_L1;
      2'd2:    edge_of = hcmc_pkg::EDGE_L2;
      default: edge_of = hcmc_pkg::EDGE_L3;
    endcase
  endfunction : edge_of

  // Static level table, levels one and two share a setting
  function automatic logic [3:0] static_of(input logic [1:0] lvl);
    case (lvl)
      2'd0:    static_of = hcmc_pkg::STAT_L0;
      2'd3:    static_of = hcmc_pkg::STAT_L3;
      default: static_of = hcmc_pkg::STAT_L12;
    endcase
  endfunction : static_of

  // Decode straps
  always_comb begin
    o_comp.edge_lvl   = edge_of(i_boost_level);
    o_comp.static_lvl = static_of(i_boost_level);
    case (i_rx_strap)
      hcmc_pkg::RXS_LOW:  o_comp.rx_gain = hcmc_pkg::RX_LOW;
      hcmc_pkg::RXS_HIGH: o_comp.rx_gain = hcmc_pkg::RX_HIGH;
      default:            o_comp.rx_gain = hcmc_pkg::RX_MID; // Unresolved reads as mid
    endcase
  end
endmodule : hcmc_strap_decode
`default_nettype wire

// File: hcmc_i2c_target.sv
// Byte-oriented serial target: pointer write then data write or read.
// Assumes bus pins are sampled synchronously; clock far above the bus rate.
`default_nettype none
module hcmc_i2c_target (
  input  wire logic                  i_clk,      // System clock
  input  wire logic                  i_arst_n,   // Async reset, active low
  input  wire logic                  i_ce,       // Clock enable
  input  wire logic                  i_en,       // Target enabled
  input  wire logic                  i_scl,      // Bus clock level
  input  wire logic                  i_sda,      // Bus data level
  input  wire logic [7:0]            i_rdata,    // Read data at pointer
  output logic                       o_sda_oe_n, // Low while pulling data low
  output logic [7:0]                 o_ptr,      // Register pointer
  output hcmc_pkg::hcmc_wreq_t       o_wreq      // Write pulse
);
  typedef enum {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK} hcmc_ist_t;
  hcmc_ist_t  st_reg;
  logic       scl_q, sda_q, rw_reg, first_reg, nack_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg, tx_reg;
  logic       start_c, stop_c, rise_c, fall_c;

  // Bus event detection; any sample rate well above 400 kHz works
  assign start_c = scl_q & i_scl & sda_q & ~i_sda;
  assign stop_c  = scl_q & i_scl & ~sda_q & i_sda;
  assign rise_c  = ~scl_q & i_scl;
  assign fall_c  = scl_q & ~i_scl;

  // Protocol engine
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= I_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      nack_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      o_sda_oe_n <= 1'b1;
      o_ptr <= 8'h00;
      o_wreq <= '0;
    end else if (i_ce) begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      o_wreq.wr <= 1'b0;
      if (!i_en || stop_c) begin
        st_reg <= I_IDLE;
        o_sda_oe_n <= 1'b1;
      end else if (start_c) begin
        st_reg <= I_ADDR;
        cnt_reg <= 4'h0;
        first_reg <= 1'b1;
        o_sda_oe_n <= 1'b1;
      end else if (rise_c) begin
        if (st_reg == I_ADDR || st_reg == I_WR) begin
          sh_reg <= {sh_reg[6:0], i_sda};
          cnt_reg <= cnt_reg + 4'h1;
        end
        if (st_reg == I_RACK) begin
          nack_reg <= i_sda;
        end
      end else if (fall_c) begin
        case (st_reg)
          I_ADDR: if (cnt_reg == 4'h8) begin
            if (sh_reg[7:1] == hcmc_pkg::TGT_ADDR) begin
              o_sda_oe_n <= 1'b0;
              rw_reg <= sh_reg[0];
              st_reg <= I_AACK;
            end else begin
              st_reg <= I_IDLE;
            end
          end
          I_AACK, I_RACK: begin
            if (st_reg == I_RACK && nack_reg) begin
              o_sda_oe_n <= 1'b1;
              st_reg <= I_IDLE;
            end else if (rw_reg) begin
              tx_reg <= i_rdata;
              o_sda_oe_n <= i_rdata[7];
              cnt_reg <= 4'h1;
              st_reg <= I_RD;
            end else begin
              o_sda_oe_n <= 1'b1;
              cnt_reg <= 4'h0;
              st_reg <= I_WR;
            end
          end
          I_WR: if (cnt_reg == 4'h8) begin
            o_sda_oe_n <= 1'b0;
            st_reg <= I_WACK;
            if (first_reg) begin
              o_ptr <= sh_reg;
              first_reg <= 1'b0;
            end else begin
              o_wreq <= '{wr: 1'b1, addr: o_ptr, data: sh_reg};
              o_ptr <= o_ptr + 8'h01;
            end
          end
          I_WACK: begin
            o_sda_oe_n <= 1'b1;
            cnt_reg <= 4'h0;
            st_reg <= I_WR;
          end
          I_RD: begin
            if (cnt_reg == 4'h8) begin
              o_sda_oe_n <= 1'b1; // Release for controller acknowledge
              o_ptr <= o_ptr + 8'h01;
              st_reg <= I_RACK;
            end else begin
              o_sda_oe_n <= tx_reg[6];
              tx_reg <= {tx_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule : hcmc_i2c_target
`default_nettype wire

// File: hcmc_mode_ctrl.sv
// Mode control, strap capture and register bank of the signal conditioner.
// Assumes speed and fixture detection come from the analog front end as
// synchronous levels, and strap pins are resolved to codes beforehand.
`default_nettype none
module hcmc_mode_ctrl (
  input  wire logic       i_clk,                  // 100 MHz clock
  input  wire logic       i_arst_n,               // Async reset, active low
  input  wire logic       i_ce,                   // Clock enable
  input  wire logic       i_shutdown_n_input,     // Shutdown, active low
  input  wire logic [1:0] i_conn_speed,           // Detected line speed
  input  wire logic       i_fixture_det,          // Compliance fixture seen
  input  wire logic [1:0] i_boost_level,          // Boost strap level
  input  wire logic [1:0] i_receive_gain_strap,   // Three-state strap code
  input  wire logic       i_charge_port_enable_n, // Charge port enable, low
  input  wire logic       i_scl,                  // Bus clock level
  input  wire logic       i_sda,                  // Bus data level
  output logic            o_sda_out,              // Data drive level
  output logic            o_sda_oe_n,             // Low while driving data
  output logic            o_connect_indicator,    // Connect indicator
  output logic            o_hs_active_indicator,  // High-speed indicator
  output logic            o_comp_en,              // Compensation enable
  output logic            o_passthrough,          // Straight-through path
  output logic [3:0]      o_edge_level,           // Applied edge level
  output logic [3:0]      o_static_level,         // Applied static level
  output logic [7:0]      o_rx_gain,              // Applied receive gain
  output logic            o_charge_port_en,       // Charge controller enable
  output logic            o_serial_mode           // Serial target enabled
);
  typedef enum {ST_SHUT, ST_WAKE, ST_IDLE, ST_LS, ST_FS, ST_HS, ST_EYE} hcmc_st_t;

  hcmc_st_t                       st_reg, st_next;
  logic [hcmc_pkg::WAKE_CNT_W-1:0] wake_cnt_reg;
  logic                           was_hs_reg;
  logic                           wake_done;
  logic [7:0]                     edge_reg, cfg_reg, static_reg, rx_reg;
  logic [7:0]                     rdata_reg;
  logic [7:0]                     ptr;
  hcmc_pkg::hcmc_wreq_t           wreq;
  hcmc_pkg::hcmc_comp_t           strap_comp;
  logic                           hold;
  logic                           sda_oe_n_int;

  localparam logic [hcmc_pkg::WAKE_CNT_W-1:0] WAKE_LAST =
    hcmc_pkg::WAKE_CNT_W'(hcmc_pkg::WAKE_SAMPLE_CYC - 1);

  // Strap decoding
  hcmc_strap_decode u_strap (
    .i_boost_level (i_boost_level),
    .i_rx_strap    (i_receive_gain_strap),
    .o_comp        (strap_comp)
  );

  // Serial register access
  hcmc_i2c_target u_tgt (
    .i_clk      (i_clk),
    .i_arst_n   (i_arst_n),
    .i_ce       (i_ce),
    .i_en       (o_serial_mode),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .i_rdata    (rdata_reg),
    .o_sda_oe_n (sda_oe_n_int),
    .o_ptr      (ptr),
    .o_wreq     (wreq)
  );

  // Configuration hold only counts when the serial path exists
  assign hold      = o_serial_mode & cfg_reg[hcmc_pkg::CFG_HOLD_BIT];
  assign wake_done = (st_reg == ST_WAKE) && (wake_cnt_reg == WAKE_LAST);

  // Mode sequencing
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_SHUT: st_next = ST_WAKE;
      ST_WAKE: if (wake_done) begin
        st_next = was_hs_reg ? ST_EYE : ST_IDLE;
      end
      ST_IDLE: begin
        if (i_fixture_det) begin
          st_next = ST_EYE;
        end else if (i_conn_speed == hcmc_pkg::SPD_HS) begin
          st_next = ST_HS;
        end else if (i_conn_speed == hcmc_pkg::SPD_FS) begin
          st_next = ST_FS;
        end else if (i_conn_speed == hcmc_pkg::SPD_LS) begin
          st_next = ST_LS;
        end
      end
      ST_LS: if (i_conn_speed != hcmc_pkg::SPD_LS) begin
        st_next = ST_IDLE;
      end
      ST_FS: begin
        if (i_conn_speed == hcmc_pkg::SPD_HS) begin
          st_next = ST_HS; // Chirp upgrades a full-speed link
        end else if (i_conn_speed != hcmc_pkg::SPD_FS) begin
          st_next = ST_IDLE;
        end
      end
      ST_HS: if (i_conn_speed != hcmc_pkg::SPD_HS) begin
        st_next = ST_IDLE;
      end
      ST_EYE: if (!i_fixture_det && i_conn_speed == hcmc_pkg::SPD_NONE) begin
        st_next = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
    // Held configuration parks the machine; it restarts from idle on release
    if (hold && st_reg != ST_WAKE && st_reg != ST_SHUT) begin
      st_next = ST_IDLE;
    end
  end

  // State register; shutdown overrides everything
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= ST_SHUT;
    end else if (i_ce) begin
      if (!i_shutdown_n_input) begin
        st_reg <= ST_SHUT;
      end else begin
        st_reg <= st_next;
      end
    end
  end

  // Remember high-speed operation across a shutdown pulse
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      was_hs_reg <= 1'b0;
    end else if (i_ce) begin
      if (!i_shutdown_n_input) begin
        if (st_reg == ST_HS) begin
          was_hs_reg <= 1'b1;
        end
      end else if (st_reg != ST_SHUT && st_reg != ST_WAKE) begin
        was_hs_reg <= 1'b0;
      end
    end
  end

  // Settle delay after leaving shutdown before straps are sampled
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wake_cnt_reg <= '0;
    end else if (i_ce) begin
      if (st_reg == ST_WAKE) begin
        wake_cnt_reg <= wake_cnt_reg + 1'b1;
      end else begin
        wake_cnt_reg <= '0;
      end
    end
  end

  // Serial mode latched from both bus lines at the sample point
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_serial_mode <= 1'b0;
    end else if (i_ce) begin
      if (st_reg == ST_SHUT) begin
        o_serial_mode <= 1'b0;
      end else if (wake_done) begin
        o_serial_mode <= i_scl & i_sda;
      end
    end
  end

  // Register bank: strap load at wake, serial writes otherwise
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      edge_reg   <= {hcmc_pkg::EDGE_RST[7:4], hcmc_pkg::EDGE_RSVD_RST};
      cfg_reg    <= hcmc_pkg::CONFIG_RST;
      static_reg <= {hcmc_pkg::STATIC_RSVD_RST, hcmc_pkg::STATIC_RST[3:0]};
      rx_reg     <= hcmc_pkg::RXGAIN_RST;
    end else if (i_ce) begin
      if (wake_done) begin
        edge_reg[7:hcmc_pkg::EDGE_LVL_LSB] <= strap_comp.edge_lvl;
        edge_reg[3:0] <= hcmc_pkg::EDGE_RSVD_RST;
        static_reg[hcmc_pkg::STATIC_LVL_LSB+:4] <= strap_comp.static_lvl;
        rx_reg <= strap_comp.rx_gain;
        cfg_reg <= hcmc_pkg::CONFIG_RST;
      end else if (wreq.wr) begin
        // Unlisted offsets are not stored
        case (wreq.addr)
          hcmc_pkg::OFS_EDGE:   edge_reg   <= wreq.data;
          hcmc_pkg::OFS_CONFIG: cfg_reg    <= wreq.data;
          hcmc_pkg::OFS_STATIC: static_reg <= wreq.data;
          hcmc_pkg::OFS_RXGAIN: rx_reg     <= wreq.data;
          default: ;
        endcase
      end
    end
  end

  // Read data for the pointer, one cycle behind it, far ahead of the bus
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_reg <= hcmc_pkg::UNMAPPED_RD;
    end else if (i_ce) begin
      case (ptr)
        hcmc_pkg::OFS_EDGE:   rdata_reg <= edge_reg;
        hcmc_pkg::OFS_CONFIG: rdata_reg <= cfg_reg;
        hcmc_pkg::OFS_STATIC: rdata_reg <= static_reg;
        hcmc_pkg::OFS_RXGAIN: rdata_reg <= rx_reg;
        default:              rdata_reg <= hcmc_pkg::UNMAPPED_RD;
      endcase
    end
  end

  // Applied settings follow the registers only outside configuration mode,
  // so a half-edited set never reaches the booster
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_edge_level   <= hcmc_pkg::EDGE_RST[7:4];
      o_static_level <= hcmc_pkg::STATIC_RST[3:0];
      o_rx_gain      <= hcmc_pkg::RXGAIN_RST;
    end else if (i_ce && !hold && st_reg != ST_WAKE) begin
      o_edge_level   <= edge_reg[7:hcmc_pkg::EDGE_LVL_LSB];
      o_static_level <= static_reg[hcmc_pkg::STATIC_LVL_LSB+:4];
      o_rx_gain      <= rx_reg;
    end
  end

  // Indicators and compensation per mode
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_connect_indicator   <= 1'b0;
      o_hs_active_indicator <= 1'b0;
      o_comp_en             <= 1'b0;
      o_passthrough         <= 1'b1;
    end else if (i_ce) begin
      o_passthrough <= (st_next == ST_SHUT) || !i_shutdown_n_input;
      if (!i_shutdown_n_input) begin
        o_connect_indicator   <= 1'b0;
        o_hs_active_indicator <= 1'b0;
        o_comp_en             <= 1'b0;
      end else begin
        case (st_next)
          ST_LS, ST_FS: begin
            o_connect_indicator   <= 1'b1;
            o_hs_active_indicator <= 1'b0;
            o_comp_en             <= 1'b0;
          end
          ST_HS: begin
            o_connect_indicator   <= 1'b1;
            o_hs_active_indicator <= 1'b1;
            o_comp_en             <= 1'b1;
          end
          ST_EYE: begin
            o_connect_indicator   <= 1'b0;
            o_hs_active_indicator <= 1'b1;
            o_comp_en             <= 1'b1;
          end
          default: begin
            o_connect_indicator   <= 1'b0;
            o_hs_active_indicator <= 1'b0;
            o_comp_en             <= 1'b0;
          end
        endcase
      end
    end
  end

  // Charge port enable and open-drain data pin
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_charge_port_en <= 1'b0;
      o_sda_out        <= 1'b0;
      o_sda_oe_n       <= 1'b1;
    end else if (i_ce) begin
      o_charge_port_en <= ~i_charge_port_enable_n;
      o_sda_out        <= 1'b0; // Open drain only ever pulls low
      o_sda_oe_n       <= sda_oe_n_int;
    end
  end
endmodule : hcmc_mode_ctrl
`default_nettype wire

// File: hcmc_end.sv
// Intentionally minimal: holds nothing.
`default_nettype none
`default_nettype wire

// File: hcmc_mode_ctrl_properties.sv
// Checker for the mode control: indicators, bypass and pin relations.
// Assumes it is bound to hcmc_mode_ctrl and sees only that module's ports.
`default_nettype none
module hcmc_mode_ctrl_properties (
  input wire logic       i_clk,                  // Clock
  input wire logic       i_arst_n,               // Reset, low
  input wire logic       i_ce,                   // Clock enable
  input wire logic       i_shutdown_n_input,     // Shutdown, low
  input wire logic [1:0] i_conn_speed,           // Line speed
  input wire logic       i_fixture_det,          // Fixture seen
  input wire logic       i_charge_port_enable_n, // Charge, low
  input wire logic       o_sda_out,              // Data level
  input wire logic       o_connect_indicator,    // Connect
  input wire logic       o_hs_active_indicator,  // High speed
  input wire logic       o_comp_en,              // Compensation
  input wire logic       o_passthrough,          // Bypass
  input wire logic       o_charge_port_en,       // Charge on
  input wire logic       o_serial_mode           // Serial on
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Serial mode may park the machine and wake shows no mode: both are left out
  logic       quiet;
  logic [6:0] wk_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wk_reg <= 7'h6E;
    end else if (i_ce) begin
      wk_reg <= !i_shutdown_n_input ? 7'h6E : wk_reg - 7'(wk_reg != 7'h00);
    end
  end
  assign quiet = i_ce && i_shutdown_n_input && !i_fixture_det && !o_serial_mode &&
    wk_reg == 7'h00;
  // Three steady cycles allow a pass through idle; eye test mode is excluded
  property p_run(s, h);
    (quiet && i_conn_speed == s)[*3] ##0 (o_connect_indicator || !o_hs_active_indicator)
      |=> o_connect_indicator && o_hs_active_indicator == h;
  endproperty
  AST_LS_MODE: assert property (p_run(hcmc_pkg::SPD_LS, 1'b0))
    else $error("Low speed indicators wrong");
  AST_FS_MODE: assert property (p_run(hcmc_pkg::SPD_FS, 1'b0))
    else $error("Full speed indicators wrong");
  AST_HS_MODE: assert property (p_run(hcmc_pkg::SPD_HS, 1'b1))
    else $error("High speed indicators wrong");
  AST_HS_COMP: assert property (o_hs_active_indicator == o_comp_en)
    else $error("Compensation does not follow high speed indicator");
  AST_SHUT: assert property (i_ce && !i_shutdown_n_input |=> !o_connect_indicator &&
    !o_hs_active_indicator && !o_comp_en && o_passthrough) else $error("Shutdown outputs wrong");
  AST_WAKE_BYPASS: assert property (i_ce && $rose(i_shutdown_n_input) |->
    o_passthrough ##1 !o_passthrough) else $error("Bypass wrong at wake");
  AST_CHARGE: assert property (i_ce |=>
    o_charge_port_en == !$past(i_charge_port_enable_n)) else $error("Charge port enable wrong");
  AST_SDA_LOW: assert property (o_sda_out == 1'b0)
    else $error("Data line driven high");
  COV_HS: cover property (o_connect_indicator && o_hs_active_indicator);
  COV_EYE: cover property (!o_connect_indicator && o_hs_active_indicator);
  COV_CHARGE: cover property (o_charge_port_en);
endmodule : hcmc_mode_ctrl_properties
bind hcmc_mode_ctrl hcmc_mode_ctrl_properties u_props (.i_clk, .i_arst_n, .i_ce,
  .i_shutdown_n_input, .i_conn_speed, .i_fixture_det, .i_charge_port_enable_n, .o_sda_out,
  .o_connect_indicator, .o_hs_active_indicator, .o_comp_en, .o_passthrough,
  .o_charge_port_en, .o_serial_mode);
`default_nettype wire

// File: hcmc_host_model.sv
// Serial bus controller model for the conditioner's register bank.
// Assumes the bench resolves the open-drain data line into i_sda.
`default_nettype none
module hcmc_host_model (
  input  wire logic i_clk,    // Bench clock
  input  wire logic i_sda,    // Resolved data line
  output var logic  o_scl,    // Bus clock
  output var logic  o_sda_drv // Low pulls data low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_scl = 1'b1;
    o_sda_drv = 1'b1;
  end
  // Four clocks a phase, above the target's minimum
  task automatic ph(input logic c, input logic d);
    @(posedge i_clk);
    o_scl <= c;
    o_sda_drv <= d;
    repeat (3) @(posedge i_clk);
  endtask : ph
  // Start when s is high, stop when low
  task automatic cond(input logic s);
    ph(1'b0, s);
    ph(1'b1, s);
    ph(1'b1, ~s);
  endtask : cond
  // Nine bits a byte, the last for acknowledge
  task automatic xfer(input logic [8:0] b, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, b[i]);
      ph(1'b1, b[i]);
      r[i] = i_sda;
    end
  endtask : xfer
  // Pointer write, then one data byte written or read with a final decline
  task automatic acc(input logic rd, input logic [7:0] ofs, wd, output logic [7:0] d);
    logic [8:0] r;
    cond(1'b1);
    xfer({hcmc_pkg::TGT_ADDR, 2'b01}, r);
    xfer({ofs, 1'b1}, r);
    if (rd) begin
      cond(1'b1);
      xfer({hcmc_pkg::TGT_ADDR, 2'b11}, r);
    end
    xfer(rd ? 9'h1FF : {wd, 1'b1}, r);
    cond(1'b0);
    d = r[8:1];
  endtask : acc
endmodule : hcmc_host_model
`default_nettype wire

// File: tb_top.sv
// Bench for the conditioner mode control: straps, register bus and modes.
// Assumes the package, design, checker and controller model compile first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string nm; logic [7:0] v;} hcmc_note_t;
  logic       i_clk = 1'b0, i_arst_n = 1'b0, i_ce = 1'b1, i_shutdown_n_input = 1'b1, res_v = 1'b0;
  logic       i_fixture_det = 1'b0, i_charge_port_enable_n = 1'b1, i_scl, sda_drv, bus_low = 1'b0;
  logic [1:0] i_conn_speed = 2'h0, i_boost_level = 2'h0, i_receive_gain_strap = 2'h0;
  logic       o_sda_out, o_sda_oe_n, o_connect_indicator, o_hs_active_indicator, o_comp_en;
  logic       o_passthrough, o_charge_port_en, o_serial_mode;
  logic [3:0] o_edge_level, o_static_level;
  logic [7:0] o_rx_gain, res;
  wire  logic i_sda;
  wire  logic [7:0] mode_w;
  hcmc_note_t q[$];
  hcmc_note_t n;
  int         failures = 0;
  int         num_checks = 0;
  // Wired-AND data line; bus_low holds it low at wake
  assign i_sda = sda_drv & (o_sda_oe_n | o_sda_out) & ~bus_low;
  assign mode_w = {5'h00, o_connect_indicator, o_hs_active_indicator, o_comp_en};
  always #5 i_clk = ~i_clk;
  hcmc_mode_ctrl uut (.i_clk, .i_arst_n, .i_ce, .i_shutdown_n_input, .i_conn_speed, .i_fixture_det,
    .i_boost_level, .i_receive_gain_strap, .i_charge_port_enable_n, .i_scl, .i_sda, .o_sda_out,
    .o_sda_oe_n, .o_connect_indicator, .o_hs_active_indicator, .o_comp_en, .o_passthrough,
    .o_edge_level, .o_static_level, .o_rx_gain, .o_charge_port_en, .o_serial_mode);
  hcmc_host_model u_host (.i_clk, .i_sda, .o_scl(i_scl), .o_sda_drv(sda_drv));
  // Watcher: each result is matched against the oldest note
  always @(posedge i_clk) begin
    if (res_v) begin
      n = q.pop_front();
      num_checks++;
      if (n.v !== res) begin
        failures++;
        $display("ERROR %s expected %h seen %h", n.nm, n.v, res);
      end
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    q.push_back('{nm, e});
    res <= g;
    res_v <= 1'b1;
    @(posedge i_clk);
    res_v <= 1'b0;
    @(posedge i_clk);
  endtask : chk
  task automatic rchk(input string nm, input logic [7:0] ofs, e);
    logic [7:0] d;
    u_host.acc(1'b1, ofs, 8'h00, d);
    chk(nm, e, d);
  endtask : rchk
  // Shutdown pulse, then the full wake period
  task automatic wake();
    i_shutdown_n_input <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("bypass", 8'h01, {7'h0, o_passthrough});
    i_shutdown_n_input <= 1'b1;
    repeat (110) @(posedge i_clk);
  endtask : wake
  task automatic close_out();
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    logic [7:0] d, sv, gv;
    logic [1:0] rv;
    logic [3:0] et [4] = '{4'h0, 4'h3, 4'h6, 4'hA};
    logic [3:0] st [4] = '{4'h0, 4'h2, 4'h2, 4'h6};
    logic [7:0] rt [4] = '{8'h00, 8'h33, 8'h66, 8'h33};
    void'($urandom(26687));
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    // Every boost level with a random gain code, captured at wake
    for (int l = 0; l < 4; l++) begin
      rv = 2'(l + $urandom % 4);
      i_boost_level <= 2'(l);
      i_receive_gain_strap <= rv;
      wake();
      rchk("edge", hcmc_pkg::OFS_EDGE, {et[l], 4'h0});
      rchk("static", hcmc_pkg::OFS_STATIC, {4'h0, st[l]});
      rchk("rxgain", hcmc_pkg::OFS_RXGAIN, rt[rv]);
      rchk("config", hcmc_pkg::OFS_CONFIG, 8'h01);
    end
    rchk("unmapped", 8'h02, 8'h00);
    i_conn_speed <= 2'h3;
    repeat (6) @(posedge i_clk);
    chk("parked", 8'h00, mode_w);
    sv = 8'($urandom);
    gv = 8'($urandom);
    u_host.acc(1'b1, hcmc_pkg::OFS_EDGE, 8'h00, d);
    u_host.acc(1'b0, hcmc_pkg::OFS_EDGE, {4'hF, d[3:0]}, d);
    u_host.acc(1'b0, hcmc_pkg::OFS_STATIC, sv, d);
    u_host.acc(1'b0, hcmc_pkg::OFS_RXGAIN, gv, d);
    u_host.acc(1'b0, hcmc_pkg::OFS_CONFIG, 8'h00, d);
    repeat (6) @(posedge i_clk);
    chk("edge_applied", 8'h0F, {4'h0, o_edge_level});
    chk("static_applied", {4'h0, sv[3:0]}, {4'h0, o_static_level});
    chk("rx_applied", gv, o_rx_gain);
    chk("hs_mode", 8'h07, mode_w);
    // Data line held low at wake leaves the straps in charge
    bus_low <= 1'b1;
    wake();
    chk("serial_off", 8'h00, {7'h0, o_serial_mode});
    chk("eye_pulse", 8'h03, mode_w);
    chk("strap_edge", {4'h0, et[3]}, {4'h0, o_edge_level});
    for (int s = 0; s < 4; s++) begin
      i_conn_speed <= 2'(s);
      repeat (6) @(posedge i_clk);
      chk("mode", s == 3 ? 8'h07 : (s == 0 ? 8'h00 : 8'h04), mode_w);
    end
    i_conn_speed <= 2'h0;
    i_fixture_det <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk("eye_fixture", 8'h03, mode_w);
    i_charge_port_enable_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("charge", 8'h01, {7'h0, o_charge_port_en});
    close_out();
  end
  // Watchdog far beyond the expected run
  initial begin
    repeat (60000) @(posedge i_clk);
    failures++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
